// File: core/usart_core.v
// Serial port interrupt, baud chain, low-power and loopback logic behind an AXI4-Lite slave
// How it works
// - Transmit request goes high one cycle after buffer empty and transmit enable are both set.
// - Receive request goes high one cycle after buffer full and receive enable are both set.
// - Writing the transmit holding buffer clears the empty flag, removing the request.
// - Reading the receive holding buffer clears the full flag, removing the request.
// - Separate two-byte vectors for transmit and receive inside 0xEC to 0xEF.
// - Transmit and receive clocks each pick external pin or internal chain.
// - Internal clock is prescaler of 1 to 16 in halves then 11-bit divisor.
// - Prescaler code one divides by one, each step adds a half, up to sixteen.
// - Prescaler code zero stops the internal chain clock entirely; a pin clock still runs the port.
// - Divisor field holds N minus one; rate is Fc over 16 N P.
// - Asynchronous divisor output is a 16x clock, divided by 16 for bits.
// - Synchronous mode uses a factor of two instead of sixteen.
// - Upper divisor bits share the prescaler register, which reset clears.
// - Low-power entry sets empty flag, clears read-only bits, keeps writable bits.
// - Low-power entry fills transmit shifter with ones; buffers keep their contents.
// - A start bit on the receive pin wakes the device from low power.
// - Crystal wake from clock stop holds execution for 256 instruction periods.
// - Both length bits set loops transmitter output into receiver input.
// - Loopback frames carry nine data bits, 7/8, one or two stops, no parity.
// - Empty flag sets when the holding buffer moves into the shifter.
// - Full flag sets when a received character reaches the holding buffer.
// - Sync select bit picks synchronous mode; clear means 16x asynchronous.
`timescale 1ns/1ps
`include "usart_defs.vh"
module usart_core #(
	parameter ADDR_W           = 5,
	parameter INSTR_CYCLE_CLKS = 1
) (
	input  wire              clk,
	input  wire              rst,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              rxPin,
	input  wire              extRateClockIn,
	input  wire              crystalOsc,
	output reg               txPin,
	output reg               txPinOe,
	output reg               extRateClockOut,
	output reg               extRateClockOe,
	output reg               txIrq,
	output reg               rxIrq,
	output reg  [7:0]        irqVector,
	output reg               lowPower,
	output reg               wakeup,
	output reg               cpuRun
);
	localparam HOLDOFF_CLKS = `HOLDOFF_PERIODS * INSTR_CYCLE_CLKS;
	localparam TX_IDLE = 1'b0;
	localparam TX_SEND = 1'b1;

	function [3:0] dataBits;
		input lo;
		input hi;
		begin
			case ({hi, lo})
				2'b01:   dataBits = 4'h7;
				2'b00:   dataBits = 4'h8;
				default: dataBits = 4'h9;
			endcase
		end
	endfunction

	function isReg;
		input [ADDR_W-1:0] a;
		input [ADDR_W-1:0] off;
		begin
			isReg = (a == off);
		end
	endfunction

	reg         txEmpty;
	reg         rxFull;
	reg         chlLo;
	reg         chlHi;
	reg         xbit9;
	reg  [7:0]  irqClk;
	reg  [7:0]  txHold;
	reg  [8:0]  rxHold;
	reg  [7:0]  presSel;
	reg  [7:0]  divLo;
	reg         haltMode;
	reg  [12:0] holdCnt;
	reg         rxPrev;
	reg         ckxPrev;
	reg         txState;
	reg  [11:0] txShift;
	reg  [3:0]  txBitsLeft;
	reg  [4:0]  txCnt;
	reg         rxBusy;
	reg  [3:0]  rxIdx;
	reg  [4:0]  rxCnt;
	reg  [8:0]  rxShift;
	reg         awHeld;
	reg         wHeld;
	reg  [ADDR_W-1:0] awAddr;
	reg  [7:0]  wByte;
	reg         wLane;
	wire        divPulse;

	wire [3:0]  nBits    = dataBits(chlLo, chlHi);
	wire        loopback = chlLo & chlHi;
	wire        syncMode = irqClk[`IC_SYNC_MODE];
	wire        ckxRise  = extRateClockIn & ~ckxPrev;
	wire        ckxFall  = ~extRateClockIn & ckxPrev;
	// Sync internal clock is the divisor output halved: one edge each way per bit
	wire        intTx    = syncMode ? (divPulse & ~extRateClockOut) : divPulse;
	wire        intRx    = syncMode ? (divPulse & extRateClockOut) : divPulse;
	wire        txTick   = irqClk[`IC_TX_EXT_CLK] ? ckxRise : intTx;
	wire        rxTick   = irqClk[`IC_RX_EXT_CLK] ? (syncMode ? ckxFall : ckxRise) : intRx;
	wire [4:0]  bitLen   = syncMode ? 5'h01 : `ASYNC_TICKS;
	wire [4:0]  lastLen  = (irqClk[`IC_STOP78] && !syncMode) ? `STOP78_TICKS : bitLen;
	wire [4:0]  curTxLen = (txBitsLeft == 4'h1) ? lastLen : bitLen;
	wire [4:0]  midTick  = syncMode ? 5'h00 : `ASYNC_MID_TICK;
	wire        rxLine   = loopback ? txPin : rxPin;
	wire [8:0]  txData9  = (nBits == 4'h9) ? {xbit9, txHold} :
	                       (nBits == 4'h8) ? {1'b1, txHold} : {2'b11, txHold[6:0]};

	wire        doWrite     = awHeld & wHeld & ~s_axi_bvalid;
	wire        next_awHeld = (awHeld | (s_axi_awvalid & s_axi_awready)) & ~doWrite;
	wire        next_wHeld  = (wHeld | (s_axi_wvalid & s_axi_wready)) & ~doWrite;
	wire        wrEn        = doWrite & wLane;
	wire        rdTake      = s_axi_arvalid & s_axi_arready;
	wire        wrTx        = wrEn & isReg(awAddr, `OFF_TX_HOLD);
	wire        rdRx        = rdTake & isReg(s_axi_araddr, `OFF_RX_HOLD);
	wire        lpEnter     = wrEn & isReg(awAddr, `OFF_POWER) & (wByte[`PW_HALT] | wByte[`PW_IDLE]) & ~lowPower;
	wire        startEdge   = lowPower & rxPrev & ~rxPin;

	baud_prescaler #(
		.DIV_W(11)
	) u_baud (
		.clk     (clk),
		.rst     (rst),
		.code    (presSel[`PS_CODE_MSB:`PS_CODE_LSB]),
		.divisor ({presSel[`PS_DIV_MSB:0], divLo}),
		.divPulse(divPulse)
	);

	// Write channel: address and data taken in either order
	always @(posedge clk) begin
		if (rst) begin
			awHeld        <= 1'b0;
			wHeld         <= 1'b0;
			awAddr        <= {ADDR_W{1'b0}};
			wByte         <= 8'h00;
			wLane         <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				awAddr <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) begin
				wByte <= s_axi_wdata[7:0];
				wLane <= s_axi_wstrb[0];
			end
			awHeld        <= next_awHeld;
			wHeld         <= next_wHeld;
			s_axi_awready <= ~next_awHeld;
			s_axi_wready  <= ~next_wHeld;
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr > `OFF_POWER || awAddr[1:0] != 2'b00) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one cycle from address to data
	always @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (rdTake) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
			if (isReg(s_axi_araddr, `OFF_CTRL_STATUS))
				s_axi_rdata[5:0] <= {xbit9, chlHi, chlLo, txState, rxFull, txEmpty};
			else if (isReg(s_axi_araddr, `OFF_IRQ_CLKSRC))
				s_axi_rdata[7:0] <= irqClk;
			else if (isReg(s_axi_araddr, `OFF_TX_HOLD))
				s_axi_rdata[7:0] <= txHold;
			else if (isReg(s_axi_araddr, `OFF_RX_HOLD))
				s_axi_rdata[8:0] <= rxHold;
			else if (isReg(s_axi_araddr, `OFF_PRESCALER))
				s_axi_rdata[7:0] <= presSel;
			else if (isReg(s_axi_araddr, `OFF_DIVISOR_LO))
				s_axi_rdata[7:0] <= divLo;
			else if (isReg(s_axi_araddr, `OFF_POWER))
				s_axi_rdata[2:0] <= {lowPower, 1'b0, 1'b0};
			else
				s_axi_rresp <= `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// Writable settings survive low-power entry untouched
	always @(posedge clk) begin
		if (rst) begin
			{xbit9, chlHi, chlLo} <= `RST_CTRL;
			irqClk  <= `RST_IRQ_CLKSRC;
			txHold  <= 8'h00;
			presSel <= `RST_PRESCALER;
			divLo   <= `RST_DIVISOR_LO;
		end else if (wrEn) begin
			if (isReg(awAddr, `OFF_CTRL_STATUS))
				{xbit9, chlHi, chlLo} <= wByte[5:3];
			if (isReg(awAddr, `OFF_IRQ_CLKSRC))
				irqClk <= wByte;
			if (wrTx)
				txHold <= wByte;
			if (isReg(awAddr, `OFF_PRESCALER))
				presSel <= wByte;
			if (isReg(awAddr, `OFF_DIVISOR_LO))
				divLo <= wByte;
		end
	end

	// Transmitter: holding buffer moves to the shifter when it falls idle
	always @(posedge clk) begin
		if (rst) begin
			txEmpty    <= 1'b1;
			txState    <= TX_IDLE;
			txShift    <= 12'hfff;
			txBitsLeft <= 4'h0;
			txCnt      <= 5'h00;
		end else begin
			if (wrTx)
				txEmpty <= 1'b0;
			if (lpEnter) begin
				txEmpty <= 1'b1;
				txState <= TX_IDLE;
				txShift <= 12'hfff;
				txCnt   <= 5'h00;
			end else if (txTick) begin
				case (txState)
					TX_IDLE: begin
						if (!txEmpty && !wrTx) begin
							txShift    <= {2'b11, txData9, 1'b0};
							txBitsLeft <= nBits + 4'h1 + (irqClk[`IC_STOP2] ? 4'h2 : 4'h1);
							txCnt      <= 5'h00;
							txState    <= TX_SEND;
							txEmpty    <= 1'b1;
						end
					end
					TX_SEND: begin
						if (txCnt == curTxLen - 5'h01) begin
							txCnt      <= 5'h00;
							txShift    <= {1'b1, txShift[11:1]};
							txBitsLeft <= txBitsLeft - 4'h1;
							if (txBitsLeft == 4'h1)
								txState <= TX_IDLE;
						end else begin
							txCnt <= txCnt + 5'h01;
						end
					end
					default: txState <= TX_IDLE;
				endcase
			end
		end
	end

	// Receiver: start checked at mid-bit, every later bit sampled once
	always @(posedge clk) begin
		if (rst) begin
			rxFull  <= 1'b0;
			rxBusy  <= 1'b0;
			rxIdx   <= 4'h0;
			rxCnt   <= 5'h00;
			rxShift <= 9'h000;
			rxHold  <= 9'h000;
		end else begin
			if (rdRx)
				rxFull <= 1'b0;
			if (lpEnter) begin
				rxBusy <= 1'b0;
				rxFull <= 1'b0;
			end else if (rxTick) begin
				if (!rxBusy) begin
					if (!rxLine) begin
						rxBusy <= 1'b1;
						// Sync: the detecting tick already was the start sample
						rxIdx  <= syncMode ? 4'h1 : 4'h0;
						rxCnt  <= 5'h00;
					end
				end else begin
					rxCnt <= (rxCnt == bitLen - 5'h01) ? 5'h00 : rxCnt + 5'h01;
					if (rxCnt == midTick) begin
						rxIdx <= rxIdx + 4'h1;
						if (rxIdx == 4'h0 && rxLine) begin
							rxBusy <= 1'b0;
						end else if (rxIdx == nBits + 4'h1) begin
							rxBusy <= 1'b0;
							rxHold <= rxShift >> (4'h9 - nBits);
							rxFull <= 1'b1;
						end else if (rxIdx != 4'h0) begin
							rxShift <= {rxLine, rxShift[8:1]};
						end
					end
				end
			end
		end
	end

	// Power state, wakeup and oscillator hold-off
	always @(posedge clk) begin
		if (rst) begin
			lowPower <= 1'b0;
			haltMode <= 1'b0;
			holdCnt  <= 13'h0000;
			wakeup   <= 1'b0;
			cpuRun   <= 1'b0;
			rxPrev   <= 1'b1;
			ckxPrev  <= 1'b0;
		end else begin
			rxPrev  <= rxPin;
			ckxPrev <= extRateClockIn;
			wakeup  <= startEdge;
			if (lpEnter) begin
				lowPower <= 1'b1;
				haltMode <= wByte[`PW_HALT];
			end else if (startEdge) begin
				lowPower <= 1'b0;
				if (haltMode && crystalOsc)
					holdCnt <= HOLDOFF_CLKS[12:0];
			end else if (holdCnt != 13'h0000) begin
				holdCnt <= holdCnt - 13'h0001;
			end
			cpuRun <= ~lowPower & ~lpEnter & ~startEdge & (holdCnt == 13'h0000) & ~(startEdge & haltMode);
		end
	end

	// Pins and interrupt requests
	always @(posedge clk) begin
		if (rst) begin
			txPin           <= 1'b1;
			txPinOe         <= 1'b0;
			extRateClockOut <= 1'b0;
			extRateClockOe  <= 1'b0;
			txIrq           <= 1'b0;
			rxIrq           <= 1'b0;
			irqVector       <= `VEC_TX;
		end else begin
			txPin   <= (txState == TX_SEND) ? txShift[0] : 1'b1;
			txPinOe <= irqClk[`IC_TX_PIN_EN];
			if (divPulse)
				extRateClockOut <= ~extRateClockOut;
			extRateClockOe <= ~(irqClk[`IC_TX_EXT_CLK] | irqClk[`IC_RX_EXT_CLK]);
			// Registered, so each request trails its flags by one cycle
			txIrq     <= txEmpty & irqClk[`IC_TX_IRQ_EN];
			rxIrq     <= rxFull & irqClk[`IC_RX_IRQ_EN];
			irqVector <= (rxFull & irqClk[`IC_RX_IRQ_EN]) ? `VEC_RX : `VEC_TX;
		end
	end
endmodule

// File: core/usart_defs.vh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef USART_DEFS_VH
`define USART_DEFS_VH
`define OFF_CTRL_STATUS   5'h00
`define OFF_IRQ_CLKSRC    5'h04
`define OFF_TX_HOLD       5'h08
`define OFF_RX_HOLD       5'h0c
`define OFF_PRESCALER     5'h10
`define OFF_DIVISOR_LO    5'h14
`define OFF_POWER         5'h18
`define CS_TX_EMPTY       0
`define CS_RX_FULL        1
`define CS_TX_BUSY        2
`define CS_CHL_LO         3
`define CS_CHL_HI         4
`define CS_XBIT9          5
`define IC_TX_IRQ_EN      0
`define IC_RX_IRQ_EN      1
`define IC_TX_EXT_CLK     2
`define IC_RX_EXT_CLK     3
`define IC_SYNC_MODE      4
`define IC_TX_PIN_EN      5
`define IC_STOP78         6
`define IC_STOP2          7
`define PS_CODE_MSB       7
`define PS_CODE_LSB       3
`define PS_DIV_MSB        2
`define PW_HALT           0
`define PW_IDLE           1
`define PW_LOW_POWER      2
`define RST_CTRL          3'h0
`define RST_IRQ_CLKSRC    8'h00
`define RST_PRESCALER     8'h00
`define RST_DIVISOR_LO    8'h00
`define VEC_RX            8'hec
`define VEC_TX            8'hee
`define ASYNC_TICKS       5'h10
`define STOP78_TICKS      5'h0e
`define ASYNC_MID_TICK    5'h07
`define HOLDOFF_PERIODS   256
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// File: core/baud_prescaler.v
// Half-step prescaler followed by the reloading divisor counter
`timescale 1ns/1ps
module baud_prescaler #(
	parameter DIV_W = 11
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [4:0]       code,
	input  wire [DIV_W-1:0] divisor,
	output reg              divPulse
);
	reg  [4:0]       preCnt;
	reg              phase;
	reg  [DIV_W-1:0] divCnt;
	wire [5:0]       total   = {1'b0, code} + 6'h01;
	wire [4:0]       shortLen = total[5:1];
	wire [4:0]       longLen  = total[5:1] + {4'h0, total[0]};
	wire [4:0]       curLen   = phase ? longLen : shortLen;
	wire             prePulse = (code != 5'h00) && (preCnt == curLen - 5'h01);
	always @(posedge clk) begin
		if (rst || code == 5'h00) begin
			preCnt   <= 5'h00;
			phase    <= 1'b0;
			divCnt   <= {DIV_W{1'b0}};
			divPulse <= 1'b0;
		end else begin
			divPulse <= 1'b0;
			if (prePulse) begin
				preCnt <= 5'h00;
				phase  <= ~phase;
				if (divCnt == 0) begin
					divCnt   <= divisor;
					divPulse <= 1'b1;
				end else begin
					divCnt <= divCnt - {{(DIV_W-1){1'b0}}, 1'b1};
				end
			end else begin
				preCnt <= preCnt + 5'h01;
			end
		end
	end
endmodule

// File: bench/usart_core_properties.sv
// Concurrent checks on the serial port bus, interrupt and wake outputs
`timescale 1ns/1ps
module usart_core_checker (
	input wire        clk,
	input wire        rst,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_arready,
	input wire        txIrq,
	input wire        rxIrq,
	input wire [7:0]  irqVector,
	input wire        lowPower,
	input wire        wakeup,
	input wire        cpuRun
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_rx_vec;
		rxIrq |-> irqVector == 8'hec;
	endproperty
	a_rx_vec: assert property (p_rx_vec)
		else $error("receive request without receive vector");
	property p_tx_vec;
		txIrq && !rxIrq |-> irqVector == 8'hee;
	endproperty
	a_tx_vec: assert property (p_tx_vec)
		else $error("transmit request without transmit vector");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block)
		else $error("read address taken while data pending");
	property p_wake_pulse;
		wakeup |=> !wakeup;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake pulse longer than one cycle");
	property p_wake_exit;
		wakeup |-> ##[0:1] !lowPower;
	endproperty
	a_wake_exit: assert property (p_wake_exit)
		else $error("low power kept after wake");
	property p_wake_cause;
		$rose(wakeup) |-> $past(lowPower);
	endproperty
	a_wake_cause: assert property (p_wake_cause)
		else $error("wake outside low power");
	property p_sleep_run;
		lowPower |-> !cpuRun;
	endproperty
	a_sleep_run: assert property (p_sleep_run)
		else $error("code runs in low power");
	c_wake: cover property (wakeup);
	c_rx: cover property ($rose(rxIrq));
	c_tx: cover property ($fell(txIrq));
endmodule
bind usart_core usart_core_checker i_chk (.clk(clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_arready(s_axi_arready),
	.txIrq(txIrq), .rxIrq(rxIrq), .irqVector(irqVector), .lowPower(lowPower), .wakeup(wakeup),
	.cpuRun(cpuRun));

// File: bench/remote_serial.sv
// Remote serial sender driving the receive line
`timescale 1ns/1ps
module remote_serial (
	input  wire clk,
	output reg  line
);
	// Idle high, as a pulled-up line would sit
	initial line = 1'h1;
	task send(input [8:0] d, input integer nb, input integer bc);
		integer i;
		begin
			for (i = 0; i <= nb + 1; i = i + 1) begin
				@(posedge clk);
				line <= (i == 0) ? 1'h0 : (i == nb + 1) ? 1'h1 : d[i-1];
				repeat (bc - 1) @(posedge clk);
			end
		end
	endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the serial port support logic
`timescale 1ns/1ps
`include "usart_defs.vh"
module testbench;
	reg         clk, rst, awvalid, wvalid, bready, arvalid, rready, crystalOsc, p, ckRun;
	reg         ckIn = 1'h0;
	reg  [4:0]  awaddr, araddr;
	reg  [31:0] wdata, rd;
	reg  [31:0] rows [0:8];
	reg  [1:0]  rs;
	wire        awready, wready, bvalid, arready, rvalid, rxPin, txPin, ckOut, ckOe;
	wire        txIrq, rxIrq, lowPower, wakeup, cpuRun, txOe;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [7:0]  vec;
	integer     mismatches, nChecks, ticks, i, n;

	usart_core i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxPin(rxPin),
		.extRateClockIn(ckIn), .crystalOsc(crystalOsc), .txPin(txPin), .txPinOe(txOe),
		.extRateClockOut(ckOut), .extRateClockOe(ckOe), .txIrq(txIrq), .rxIrq(rxIrq),
		.irqVector(vec), .lowPower(lowPower), .wakeup(wakeup), .cpuRun(cpuRun));
	remote_serial i_far (.clk(clk), .line(rxPin));

	// External rate clock, one rising edge every two cycles while enabled
	always @(posedge clk)
		ckIn <= ckRun & ~ckIn;

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	task close_out;
		begin
			$display("checks %0d mismatches %0d", nChecks, mismatches);
			if (mismatches == 0 && nChecks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	// Generous ceiling; a hung handshake ends here
	always @(posedge clk) begin
		ticks = ticks + 1;
		if (ticks == 30000) begin
			mismatches = mismatches + 1;
			close_out;
		end
	end

	task check(input [31:0] seen, input [31:0] exp, input string what);
		begin
			nChecks = nChecks + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("wrong value %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	task axiW(input [4:0] a, input [31:0] d);
		begin
			@(posedge clk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			bready <= 1'h1;
			do begin
				@(posedge clk);
				if (awvalid && awready) awvalid <= 1'h0;
				if (wvalid && wready) wvalid <= 1'h0;
			end while (bvalid !== 1'h1);
			rs = bresp;
			bready <= 1'h0;
		end
	endtask

	task axiR(input [4:0] a);
		begin
			@(posedge clk);
			araddr <= a;
			arvalid <= 1'h1;
			rready <= 1'h1;
			do begin
				@(posedge clk);
				if (arvalid && arready) arvalid <= 1'h0;
			end while (rvalid !== 1'h1);
			rd = rdata;
			rs = rresp;
			rready <= 1'h0;
		end
	endtask

	// Clock is stopped before the new rate goes in
	task setRate(input [4:0] c, input [10:0] n1);
		begin
			axiW(`OFF_PRESCALER, 32'h0);
			axiW(`OFF_DIVISOR_LO, {24'h0, n1[7:0]});
			axiW(`OFF_PRESCALER, {24'h0, c, n1[10:8]});
		end
	endtask

	// Cycles over 16 divisor pulses; half steps alternate, so pairs are exact
	task measure(output integer cyc);
		integer k;
		begin
			@(posedge clk);
			p = ckOut;
			while (ckOut === p) @(posedge clk);
			p = ckOut;
			cyc = 0;
			k = 0;
			while (k < 16) begin
				@(posedge clk);
				cyc = cyc + 1;
				if (ckOut !== p) k = k + 1;
				p = ckOut;
			end
		end
	endtask

	initial begin
		rst = 1'h1;
		{awvalid, wvalid, bready, arvalid, rready, crystalOsc, ckRun} = 7'h0;
		{awaddr, araddr, wdata} = 42'h0;
		{mismatches, nChecks, ticks} = 96'h0;
		// wr, addr, wdata, read expect, resp
		rows[0] = 32'h0000_0010;
		rows[1] = 32'h0100_0000;
		rows[2] = 32'h0140_0000;
		rows[3] = 32'h01c0_0002;
		rows[4] = 32'h102f_f002;
		rows[5] = 32'h1042_c2c0;
		rows[6] = 32'h100f_f390;
		rows[7] = 32'h1000_0010;
		rows[8] = 32'h1040_0000;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		for (i = 0; i < 9; i = i + 1) begin
			if (rows[i][28]) begin
				axiW(rows[i][24:20], {24'h0, rows[i][19:12]});
				check(rs, rows[i][1:0], "bresp");
			end
			axiR(rows[i][24:20]);
			check(rd, rows[i][11:4], "rdata");
			check(rs, rows[i][1:0], "rresp");
		end
		axiW(`OFF_IRQ_CLKSRC, 32'h24);
		repeat (2) @(posedge clk);
		check(ckOe, 0, "ckOe");
		check(txOe, 1, "txOe");
		$display("test registers done");
		for (i = 1; i < 32; i = i + 1) begin
			setRate(i[4:0], 11'h0);
			measure(n);
			check(n, 8 * (i + 1), "period");
		end
		setRate(5'h1, 11'h5);
		measure(n);
		check(n, 96, "period");
		setRate(5'h2, 11'h100);
		measure(n);
		check(n, 6168, "period");
		setRate(5'h0, 11'h0);
		n = 0;
		p = ckOut;
		repeat (64) begin
			@(posedge clk);
			if (ckOut !== p) n = n + 1;
		end
		check(n, 0, "stopped");
		$display("test rates done");
		setRate(5'h1, 11'h0);
		axiW(`OFF_CTRL_STATUS, 32'h38);
		axiW(`OFF_IRQ_CLKSRC, 32'h3);
		repeat (2) @(posedge clk);
		check(txIrq, 1, "txIrq");
		check(vec, 8'hee, "vector");
		axiW(`OFF_TX_HOLD, 32'h5a);
		axiW(`OFF_TX_HOLD, 32'ha5);
		repeat (2) @(posedge clk);
		check(txIrq, 0, "txIrq");
		for (i = 0; i < 2; i = i + 1) begin
			while (rxIrq !== 1'h1) @(posedge clk);
			check(vec, 8'hec, "vector");
			axiR(`OFF_RX_HOLD);
			check(rd, i ? 32'h1a5 : 32'h15a, "rxData");
			repeat (2) @(posedge clk);
			check(rxIrq, 0, "rxIrq");
		end
		check(txIrq, 1, "txIrq");
		axiW(`OFF_IRQ_CLKSRC, 32'h2);
		repeat (2) @(posedge clk);
		check(txIrq, 0, "txIrq");
		$display("test loopback done");
		// Internal chain stopped, pin clock drives both directions
		setRate(5'h0, 11'h0);
		ckRun <= 1'h1;
		axiW(`OFF_IRQ_CLKSRC, 32'he);
		axiW(`OFF_TX_HOLD, 32'h96);
		while (rxIrq !== 1'h1) @(posedge clk);
		axiR(`OFF_RX_HOLD);
		check(rd, 32'h196, "extClk");
		ckRun <= 1'h0;
		// Sync loopback; character left unread for the low-power test
		setRate(5'h1, 11'h0);
		axiW(`OFF_IRQ_CLKSRC, 32'h12);
		axiW(`OFF_TX_HOLD, 32'h3c);
		while (rxIrq !== 1'h1) @(posedge clk);
		$display("test clock sources done");
		axiW(`OFF_CTRL_STATUS, 32'h20);
		axiW(`OFF_TX_HOLD, 32'h77);
		// Wake source is the falling receive edge, fixed in this port
		axiW(`OFF_POWER, 32'h2);
		repeat (2) @(posedge clk);
		check(lowPower, 1, "lowPower");
		check(txPin, 1, "txPin");
		axiR(`OFF_CTRL_STATUS);
		check(rd, 32'h21, "ctrl");
		axiR(`OFF_RX_HOLD);
		check(rd, 32'h13c, "syncData");
		fork
			i_far.send(9'h55, 8, 16);
		join_none
		while (wakeup !== 1'h1) @(posedge clk);
		@(posedge clk);
		check(lowPower, 0, "lowPower");
		repeat (200) @(posedge clk);
		crystalOsc <= 1'h1;
		axiW(`OFF_POWER, 32'h1);
		fork
			i_far.send(9'h0f, 8, 16);
		join_none
		while (wakeup !== 1'h1) @(posedge clk);
		n = 0;
		while (cpuRun !== 1'h1) begin
			@(posedge clk);
			n = n + 1;
		end
		check(n >= 256 && n <= 258, 1, "holdoff");
		$display("test low power done");
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		axiR(`OFF_PRESCALER);
		check(rd, 0, "prescaler");
		check(cpuRun, 1, "cpuRun");
		$display("test reset done");
		close_out;
	end
endmodule
